// [src/uwl_defs.svh]
/*
 * Constants for the USB port wake and load detect controller: mode codes,
 * timing figures and derived cycle counts.
 * Assumes a single 250 MHz reference clock and asynchronous pin inputs.
 */
// How it works
// - Recognised wake device holds 111/010 against 011
// - Change 110 to 011 is never held
// - Transient 111 is real, with output discharge
// - Limit select plays no part in holding
// - Data lines watched only in standard/charging modes
// - D- high is low-speed, D+ high full-speed
// - D+ dropping after connect marks high-speed
// - Full-speed needs 60 s awake before recognition
// - Return from auto-charger accepted any time
// - Load detector runs only in code 0011
// - Load indication low while load charges
// - Under 45 mA over 15 s: low limit, release
// - Low limit hit re-asserts load indication
// - Re-assert discharges output over 2 s
// - After discharge, output on with high limit
`ifndef UWL_DEFS_SVH
`define UWL_DEFS_SVH

// Mode line codes, read as line 1, line 2, line 3
`define UWL_MODE_CHARGE_B  3'h7
`define UWL_MODE_STD_A     3'h2
`define UWL_MODE_STD_A2    3'h6
`define UWL_MODE_AUTO      3'h3
// Four-bit setting, mode lines then limit select
`define UWL_SET_DEEP_SLEEP 4'h3

// Clock rate and millisecond tick
`define UWL_CLK_MHZ        250
`define UWL_MS_CYCLES      (`UWL_CLK_MHZ * 1000)

// Times in milliseconds
`define UWL_T_FS_QUAL_MS   16'hEA60
`define UWL_T_LOW_CUR_MS   16'h3A99
`define UWL_T_PW_DISCH_MS  16'h07D1
`define UWL_T_MODE_DISCH_MS 16'h0064

`endif

// [src/uwl_pkg.sv]
/*
 * Types shared by the wake and load detect controller.
 * Assumes nothing beyond the constants header.
 */
package uwl_pkg;

    // Attached device class seen on the data lines
    typedef enum logic [2:0] {HID_NONE, HID_LS, HID_FS_PEND, HID_FS, HID_HS} uwl_hid_t;

    // Load detector state
    typedef enum logic [1:0] {PW_OFF, PW_CHARGE, PW_LOWLIM, PW_DISCH} uwl_pw_t;

endpackage : uwl_pkg

// [src/uwl_hold_timer.sv]
/*
 * Millisecond hold timer: counts ticks while run is high, restarts at zero
 * whenever run drops. Assumes msTick is a one-cycle pulse on ref_clk.
 */
`timescale 1ns/1ps
module uwl_hold_timer
    import uwl_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Control
    input  wire logic        msTick,
    input  wire logic        run,
    input  wire logic [15:0] limit,
    // Status
    output logic             done
);

    // Elapsed milliseconds, saturates at limit
    logic [15:0] cnt_q;

    // Count while held, restart as soon as the condition breaks
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= 16'h0000;
        else if (!run)
            cnt_q <= 16'h0000;
        else if (msTick && cnt_q != limit)
            cnt_q <= cnt_q + 16'h0001;
    end

    // Done only while the condition still holds
    assign done = run && (cnt_q == limit);

    a_timer_restart:
    assert property (@(posedge ref_clk) disable iff (rst) !run |=> cnt_q == 16'h0000)
        else $error("hold timer did not restart");

endmodule : uwl_hold_timer

// [src/uwl_port_ctrl.sv]
/*
 * USB port wake and load detect controller: classifies attached devices,
 * holds selected mode changes for wake devices, and runs the load detector
 * driving the open-drain load indication.
 * Assumes analog comparators for data lines and current, all asynchronous.
 */
`timescale 1ns/1ps
`include "uwl_defs.svh"
module uwl_port_ctrl
    import uwl_pkg::*;
#(
    parameter int MS_CYCLES = `UWL_MS_CYCLES
)
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Mode pins from host system
    input  wire logic       modeLine1,
    input  wire logic       modeLine2,
    input  wire logic       modeLine3,
    input  wire logic       limitSelect,
    input  wire logic       sysAwake,
    // Data line comparators
    input  wire logic       dPlusHigh,
    input  wire logic       dMinusHigh,
    // Output current comparators
    input  wire logic       lowCurrent,
    input  wire logic       limitHit,
    // Applied mode and wake status
    output logic [2:0]      effMode,
    output logic            wakeHold,
    output logic            wakeCapable,
    // Power path control
    output logic            outDischarge,
    output logic            lowLimitOn,
    // Open-drain load indication
    output logic            loadIndO,
    output logic            loadIndOe
);

    // Two-stage synchroniser for all pin inputs
    logic [7:0] syncA_q;
    logic [7:0] syncB_q;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            // Preload the reset mode so no false 000 code follows release
            syncA_q <= {`UWL_MODE_STD_A, 5'h00};
            syncB_q <= {`UWL_MODE_STD_A, 5'h00};
        end
        else
        begin
            syncA_q <= {modeLine1, modeLine2, modeLine3, limitSelect,
                        sysAwake, dPlusHigh, dMinusHigh, lowCurrent};
            syncB_q <= syncA_q;
        end
    end

    // Unpacked synchronised inputs; limitHit is on-chip logic, no sync
    logic [2:0] modeRaw;        // Requested mode lines
    logic       limSel;         // Limit select
    logic       awake;          // System working
    logic       dPlus;          // D+ above threshold
    logic       dMinus;         // D- above threshold
    logic       lowCur;         // Load under low threshold
    assign {modeRaw, limSel, awake, dPlus, dMinus, lowCur} = syncB_q;

    // Standard or charging mode decode, used for watching only; the hold check compares 111 and 010 itself
    function automatic logic is_std_mode(input logic [2:0] m);
        is_std_mode = (m == `UWL_MODE_CHARGE_B) || (m == `UWL_MODE_STD_A)
                   || (m == `UWL_MODE_STD_A2);
    endfunction : is_std_mode

    // Millisecond tick divider
    logic [17:0] divCnt_q;
    logic        msTick;
    assign msTick = (divCnt_q == 18'(MS_CYCLES - 1));
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            divCnt_q <= 18'h00000;
        else if (msTick)
            divCnt_q <= 18'h00000;
        else
            divCnt_q <= divCnt_q + 18'h00001;
    end

    // Device classification
    uwl_hid_t hid_q;            // Current class
    logic     watching;         // Data lines monitored
    logic     fsDone;           // Full-speed held long enough
    assign watching = is_std_mode(effMode);
    uwl_hold_timer u_fs_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .msTick  (msTick),
        .run     (watching && awake && hid_q == HID_FS_PEND),
        .limit   (`UWL_T_FS_QUAL_MS),
        .done    (fsDone)
    );

    // Classification; frozen outside the watch window so it survives sleep
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            hid_q <= HID_NONE;
        else if (watching)
        begin
            case (hid_q)
                HID_NONE:
                    if (dMinus)
                        hid_q <= HID_LS;
                    else if (dPlus)
                        hid_q <= HID_FS_PEND;
                HID_FS_PEND:
                    if (!dPlus)
                        hid_q <= HID_HS;
                    else if (fsDone)
                        hid_q <= HID_FS;
                HID_LS, HID_FS:
                    if (!dPlus && !dMinus)
                        hid_q <= HID_NONE;
                HID_HS:
                    // High-speed idles both low, so only a new D- connect leaves
                    if (dMinus)
                        hid_q <= HID_LS;
                default:
                    hid_q <= HID_NONE;
            endcase
        end
    end

    assign wakeCapable = (hid_q == HID_LS) || (hid_q == HID_FS);
    // Mode filter
    logic [2:0] effMode_q;      // Applied mode
    logic [2:0] effMode_d;
    logic       wakeHold_q;     // Override in force
    logic       holdReq;        // Change to be held

    // held transitions; 110 never held; limit select unused
    assign holdReq = wakeCapable && (modeRaw == `UWL_MODE_AUTO)
                  && ((effMode_q == `UWL_MODE_CHARGE_B) || (effMode_q == `UWL_MODE_STD_A));
    // any other request, including the return, applies at once
    assign effMode_d = holdReq ? effMode_q : modeRaw;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            effMode_q  <= `UWL_MODE_STD_A;
            wakeHold_q <= 1'b0;
        end
        else
        begin
            effMode_q  <= effMode_d;
            wakeHold_q <= holdReq;
        end
    end

    assign effMode  = effMode_q;
    assign wakeHold = wakeHold_q;
    // Load detector
    uwl_pw_t  pw_q;             // Detector state
    logic     pwActive;         // Deep-sleep setting selected
    logic     lowDone;          // Low current held long enough
    logic     modeDisch_q;      // Discharge from mode entry
    logic     dischDone;        // Discharge time elapsed
    logic     lowLim_q;         // Reduced limit engaged

    assign pwActive = ({effMode_q, limSel} == `UWL_SET_DEEP_SLEEP);
    // low-current qualification restarts when current rises
    uwl_hold_timer u_low_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .msTick  (msTick),
        .run     (pw_q == PW_CHARGE && lowCur),
        .limit   (`UWL_T_LOW_CUR_MS),
        .done    (lowDone)
    );

    // One timer serves both discharge causes; the limit is picked by cause, 2001 ms for the detector, 100 ms for mode entry
    uwl_hold_timer u_disch_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .msTick  (msTick),
        .run     (pw_q == PW_DISCH || modeDisch_q),
        .limit   (pw_q == PW_DISCH ? `UWL_T_PW_DISCH_MS : `UWL_T_MODE_DISCH_MS),
        .done    (dischDone)
    );

    // Detector sequence
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pw_q <= PW_OFF;
        else if (!pwActive)
            pw_q <= PW_OFF;
        else
        begin
            case (pw_q)
                PW_OFF:
                    pw_q <= PW_CHARGE;
                PW_CHARGE:
                    if (lowDone)
                        pw_q <= PW_LOWLIM;
                PW_LOWLIM:
                    if (limitHit)
                        pw_q <= PW_DISCH;
                PW_DISCH:
                    if (dischDone)
                        pw_q <= PW_CHARGE;
                default:
                    pw_q <= PW_OFF;
            endcase
        end
    end

    // entry into 111 discharges; a new entry wins over the end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            modeDisch_q <= 1'b0;
        else if (effMode_q != `UWL_MODE_CHARGE_B && effMode_d == `UWL_MODE_CHARGE_B)
            modeDisch_q <= 1'b1;
        else if (dischDone)
            modeDisch_q <= 1'b0;
    end

    // Reduced limit register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            lowLim_q <= 1'b0;
        else
            lowLim_q <= (pw_q == PW_LOWLIM);
    end
    assign outDischarge = modeDisch_q || (pw_q == PW_DISCH);
    assign lowLimitOn   = lowLim_q;
    // indication pulled low while charging or restarting
    assign loadIndO     = 1'b0;
    assign loadIndOe    = (pw_q == PW_CHARGE) || (pw_q == PW_DISCH);

    a_hold_wake:
    assert property (@(posedge ref_clk) disable iff (rst)
        wakeCapable && effMode_q == `UWL_MODE_STD_A && modeRaw == `UWL_MODE_AUTO
        |=> effMode_q == `UWL_MODE_STD_A && wakeHold)
        else $error("wake hold not applied");
    a_no_hold_110:
    assert property (@(posedge ref_clk) disable iff (rst)
        effMode_q == `UWL_MODE_STD_A2 && modeRaw == `UWL_MODE_AUTO
        |=> effMode_q == `UWL_MODE_AUTO)
        else $error("110 change was held");
    a_disch_on_111:
    assert property (@(posedge ref_clk) disable iff (rst)
        effMode_q != `UWL_MODE_CHARGE_B ##1 effMode_q == `UWL_MODE_CHARGE_B
        |-> outDischarge)
        else $error("no discharge on entry to 111");
    a_class_frozen:
    assert property (@(posedge ref_clk) disable iff (rst)
        !watching |=> $stable(hid_q))
        else $error("class changed outside watch modes");
    a_class_ls:
    assert property (@(posedge ref_clk) disable iff (rst)
        watching && hid_q == HID_NONE && dMinus |=> hid_q == HID_LS)
        else $error("low-speed not classified");
    a_class_hs:
    assert property (@(posedge ref_clk) disable iff (rst)
        watching && hid_q == HID_FS_PEND && !dPlus |=> hid_q == HID_HS && !wakeCapable)
        else $error("high-speed not marked");
    a_pw_gate:
    assert property (@(posedge ref_clk) disable iff (rst)
        !pwActive |=> pw_q == PW_OFF && !loadIndOe)
        else $error("load detector ran outside 0011");
    a_low_release:
    assert property (@(posedge ref_clk) disable iff (rst)
        pwActive && pw_q == PW_CHARGE && lowDone |=> !loadIndOe ##1 lowLimitOn)
        else $error("low limit or release missing");
    a_hit_reassert:
    assert property (@(posedge ref_clk) disable iff (rst)
        pwActive && pw_q == PW_LOWLIM && limitHit |=> loadIndOe && outDischarge)
        else $error("limit hit did not re-assert");
    a_disch_end:
    assert property (@(posedge ref_clk) disable iff (rst)
        pwActive && pw_q == PW_DISCH && dischDone |=> pw_q == PW_CHARGE && !lowLimitOn)
        else $error("output not back on high limit");

endmodule : uwl_port_ctrl

// [sim/uwl_far_model.sv]
/*
 * Far side model: a USB peripheral on the data lines and the system power
 * controller that watches the open-drain load indication.
 * Assumes the bench selects the peripheral kind on devKind.
 */
`timescale 1ns/1ps
module uwl_far_model
(
    // Clock
    input  wire logic       ref_clk,
    // Peripheral kind: 0 none, 1 low, 2 full, 3 high speed
    input  wire logic [1:0] devKind,
    // Load indication pin from the port
    input  wire logic       loadIndO,
    input  wire logic       loadIndOe,
    // Data line comparator levels
    output logic            dPlusHigh,
    output logic            dMinusHigh,
    // Power path choice of the system
    output logic            mainConvOn
);
    logic loadWire;   // Pulled up whenever the port lets go
    int   hsCount;    // Cycles since a high-speed connect

    assign loadWire   = loadIndOe ? loadIndO : 1'b1;
    assign mainConvOn = ~loadWire;

    // Negotiation time of a high-speed peripheral
    always @(posedge ref_clk)
    begin
        hsCount <= (devKind == 2'h3) ? hsCount + 1 : 0;
    end

    assign dMinusHigh = (devKind == 2'h1);
    // High speed drops its D+ pull-up soon after connect
    assign dPlusHigh  = (devKind == 2'h2) || (devKind == 2'h3 && hsCount < 20);
endmodule : uwl_far_model

// [sim/tb_top.sv]
/*
 * Self-checking bench for the port controller and its far side model.
 * Assumes one clock cycle per millisecond tick so long waits stay short.
 */
`timescale 1ns/1ps
module tb_top
    import uwl_pkg::*;
;
    logic       ref_clk, rst;                        // Clock and reset
    logic       modeLine1, modeLine2, modeLine3;     // Mode pins
    logic       limitSelect, sysAwake;               // Host controls
    logic       lowCurrent, limitHit;                // Current comparators
    logic [1:0] devKind;                             // Peripheral kind
    logic [2:0] effMode;                             // Applied mode
    logic       wakeHold, wakeCapable, outDischarge; // Status
    logic       lowLimitOn, loadIndO, loadIndOe;     // Power path
    logic       dPlusHigh, dMinusHigh, mainConvOn;   // Far side levels
    int         errors = 0;                          // Mismatches
    int         check_count = 0;                     // Comparisons
    int         cycles = 0;                          // Hang guard
    int         expWake;                             // Model: wake device known
    logic [2:0] expMode;                             // Model: applied mode
    logic [2:0] seq[$];                              // Mode request list

    uwl_port_ctrl #(.MS_CYCLES(1)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .modeLine1(modeLine1), .modeLine2(modeLine2), .modeLine3(modeLine3),
        .limitSelect(limitSelect), .sysAwake(sysAwake), .dPlusHigh(dPlusHigh),
        .dMinusHigh(dMinusHigh), .lowCurrent(lowCurrent), .limitHit(limitHit),
        .effMode(effMode), .wakeHold(wakeHold), .wakeCapable(wakeCapable),
        .outDischarge(outDischarge), .lowLimitOn(lowLimitOn),
        .loadIndO(loadIndO), .loadIndOe(loadIndOe));

    uwl_far_model u_far (.ref_clk(ref_clk), .devKind(devKind), .loadIndO(loadIndO),
        .loadIndOe(loadIndOe), .dPlusHigh(dPlusHigh), .dMinusHigh(dMinusHigh),
        .mainConvOn(mainConvOn));

    // Free running clock
    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    // Cut a hang short; the run needs about 83300 cycles
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            errors++;
            conclude();
        end
    end

    // Let n edges pass, then settle off the edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    // Compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Request a mode; the model decides whether it is held
    task automatic setMode(input logic [2:0] m);
        {modeLine1, modeLine2, modeLine3} = m;
        limitSelect = 1'($urandom);
        if (!(m == 3'h3 && expWake != 0 && (expMode == 3'h7 || expMode == 3'h2)))
            expMode = m;
        step(5);
        chk(8'(effMode), 8'(expMode));
        chk(8'(wakeHold), 8'(m != expMode));
    endtask : setMode

    // Final counts and verdict
    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        rst = 1'b1;
        {modeLine1, modeLine2, modeLine3} = 3'h2;
        limitSelect = 1'b0;
        sysAwake = 1'b1;
        lowCurrent = 1'b0;
        limitHit = 1'b0;
        devKind = 2'h0;
        expMode = 3'h2;
        expWake = 0;
        void'($urandom(32'hE5BC4666));
        step(8);
        rst = 1'b0;
        step(2);
        chk(8'(effMode), 8'h02);
        chk(8'(loadIndO), 8'h00);
        // No wake device: every change applies, return accepted
        seq = '{3'h7, 3'h3, 3'h7, 3'h2, 3'h3, 3'h2};
        foreach (seq[i]) setMode(seq[i]);
        $display("test plain modes done");
        // Low-speed device, held and released changes
        devKind = 2'h1;
        step(5);
        expWake = 1;
        chk(8'(wakeCapable), 8'h01);
        seq = '{3'h3, 3'h2, 3'h7, 3'h3, 3'h6};
        foreach (seq[i]) setMode(seq[i]);
        // Let the earlier 111 discharge run out first
        step(110);
        chk(8'(outDischarge), 8'h00);
        // Two-line change with a transient 111
        {modeLine1, modeLine2, modeLine3} = 3'h7;
        step(3);
        {modeLine1, modeLine2, modeLine3} = 3'h3;
        step(3);
        chk(8'(outDischarge), 8'h01);
        chk(8'(effMode), 8'h07);
        expMode = 3'h7;
        setMode(3'h6);
        setMode(3'h3);
        // Lines not watched in auto-charger mode
        devKind = 2'h0;
        step(5);
        chk(8'(wakeCapable), 8'h01);
        setMode(3'h7);
        step(5);
        expWake = 0;
        chk(8'(wakeCapable), 8'h00);
        $display("test low speed done");
        // High speed: D+ drops after connect
        devKind = 2'h3;
        step(40);
        chk(8'(wakeCapable), 8'h00);
        devKind = 2'h1;
        step(5);
        chk(8'(wakeCapable), 8'h01);
        devKind = 2'h0;
        step(5);
        chk(8'(wakeCapable), 8'h00);
        // A short sleep spell restarts the full-speed wait
        devKind = 2'h2;
        step(1000);
        sysAwake = 1'b0;
        step(5);
        sysAwake = 1'b1;
        // system stays awake through the window
        step(59990);
        chk(8'(wakeCapable), 8'h00);
        step(20);
        chk(8'(wakeCapable), 8'h01);
        $display("test full speed done");
        // Load detector in deep-sleep setting
        {modeLine1, modeLine2, modeLine3} = 3'h1;
        limitSelect = 1'b1;
        lowCurrent = 1'b1;
        step(6);
        chk(8'(loadIndOe), 8'h01);
        chk(8'(mainConvOn), 8'h01);
        step(5000);
        lowCurrent = 1'b0;
        step(3);
        lowCurrent = 1'b1;
        step(14990);
        chk(8'(loadIndOe), 8'h01);
        step(20);
        chk(8'(loadIndOe), 8'h00);
        chk(8'(lowLimitOn), 8'h01);
        limitHit = 1'b1;
        step(1);
        limitHit = 1'b0;
        step(3);
        chk(8'(loadIndOe), 8'h01);
        step(1998);
        chk(8'(outDischarge), 8'h01);
        step(20);
        chk(8'(outDischarge), 8'h00);
        chk(8'(lowLimitOn), 8'h00);
        limitSelect = 1'b0;
        step(5);
        chk(8'(loadIndOe), 8'h00);
        $display("test load detect done");
        conclude();
    end
endmodule : tb_top
